// ---- rtl/urtfc_core.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "urtfc_regs.svh"
module urtfc_core (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  input wire logic rxd_in,
  output logic txd_out,
  input wire logic cts_in,
  input wire logic dsr_in,
  input wire logic ri_in,
  input wire logic dcd_in,
  output logic dtr_out,
  output logic rts_out,
  output logic irq_out
);
  import urtfc_pkg::*;
  // ****************
  // registers
  // ****************
  logic [15:0] divisor;
  logic [3:0] ier;
  logic fifo_en;
  logic [1:0] trig;
  logic [7:0] line_ctl;
  logic [1:0] modem_ctl;
  logic [7:0] scratch;
  logic div_sel;
  logic tx_push;
  logic rx_pop;
  logic fifo_wr;
  logic rx_clr;
  logic tx_clr;
  logic [4:0] lim;
  logic lstat_rd;
  logic mstat_rd;

  assign div_sel = line_ctl[`URT_LINE_DIVSEL];
  assign tx_push = wr_in && addr_in == `URT_OFF_DATA && !div_sel;
  assign rx_pop = rd_in && addr_in == `URT_OFF_DATA && !div_sel;
  assign fifo_wr = wr_in && addr_in == `URT_OFF_FIFO;
  // toggling the enable also flushes, so stale bytes never cross modes
  assign rx_clr = fifo_wr && (wdata_in[`URT_FIFO_RXCLR] || wdata_in[`URT_FIFO_EN] != fifo_en);
  assign tx_clr = fifo_wr && (wdata_in[`URT_FIFO_TXCLR] || wdata_in[`URT_FIFO_EN] != fifo_en);
  assign lim = fifo_en ? `URT_FIFO_DEPTH : 5'h01;
  assign lstat_rd = rd_in && addr_in == `URT_OFF_LSTAT;
  assign mstat_rd = rd_in && addr_in == `URT_OFF_MSTAT;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      divisor <= `URT_DIV_RST;
      ier <= 4'h0;
      fifo_en <= 1'b0;
      trig <= 2'h0;
      line_ctl <= 8'h00;
      modem_ctl <= 2'h0;
      scratch <= 8'h00;
    end else if (wr_in) begin
      case (addr_in)
        `URT_OFF_DATA: if (div_sel) divisor[7:0] <= wdata_in;
        `URT_OFF_IER: begin
          if (div_sel) begin
            divisor[15:8] <= wdata_in;
          end else begin
            ier <= wdata_in[3:0];
          end
        end
        `URT_OFF_FIFO: begin
          fifo_en <= wdata_in[`URT_FIFO_EN];
          trig <= wdata_in[7:6];
        end
        `URT_OFF_LINE: line_ctl <= wdata_in;
        `URT_OFF_MODEM: modem_ctl <= wdata_in[1:0];
        `URT_OFF_SCRATCH: scratch <= wdata_in;
        default: ;
      endcase
    end
  end

  // ****************
  // baud ticks
  // ****************
  // a 1.8432 MHz reference is made by phase accumulation, so the
  // rate is exact on average with one clock of jitter per tick
  logic [27:0] acc;
  logic ref_tick;
  logic [15:0] div_cnt;
  logic tick16;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= 28'h0000000;
      ref_tick <= 1'b0;
    end else if (acc >= 28'(`URT_CLK_HZ - `URT_REF_HZ)) begin
      acc <= acc + 28'(`URT_REF_HZ) - 28'(`URT_CLK_HZ);
      ref_tick <= 1'b1;
    end else begin
      acc <= acc + 28'(`URT_REF_HZ);
      ref_tick <= 1'b0;
    end
  end

  // divisor 0 halts the line
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt <= 16'h0000;
      tick16 <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (ref_tick && divisor != 16'h0000) begin
        if (div_cnt >= divisor - 16'h0001) begin
          div_cnt <= 16'h0000;
          tick16 <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end
  end

  // ****************
  // transmit path
  // ****************
  logic [4:0] tx_count;
  logic [7:0] tx_head;
  logic tx_take;
  logic tx_busy;
  logic tx_line;

  urtfc_fifo #(.W(8)) u_tx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(tx_clr),
    .lim_in(lim),
    .push_in(tx_push),
    .push_data_in(wdata_in),
    .pop_in(tx_take),
    .count_out(tx_count),
    .head_out(tx_head)
  );

  urtfc_tx u_tx (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tick_in(tick16),
    .valid_in(tx_count != 5'h00),
    .data_in(tx_head),
    .fmt_in(line_ctl[5:0]),
    .take_out(tx_take),
    .busy_out(tx_busy),
    .line_out(tx_line)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      txd_out <= 1'b1;
    end else begin
      txd_out <= tx_line && !line_ctl[`URT_LINE_BREAK];
    end
  end

  // ****************
  // receive path
  // ****************
  urtfc_rx_state_t rx_state;
  logic rx_prev;
  logic [3:0] rx_tcnt;
  logic [3:0] rx_idx;
  logic [8:0] rx_sh;
  logic rx_done;
  logic [10:0] rx_word;
  logic [4:0] rx_count;
  logic [10:0] rx_head;
  logic [3:0] rx_len;
  logic [3:0] rx_last;
  logic [7:0] rx_data;
  logic rx_pe;

  assign rx_len = 4'h5 + 4'(line_ctl[1:0]);
  assign rx_last = rx_len + 4'(line_ctl[`URT_LINE_PAR]) - 4'h1;
  assign rx_data = urtfc_mask(rx_sh[7:0], line_ctl[1:0]);
  assign rx_pe = line_ctl[`URT_LINE_PAR] && (rx_sh[rx_len] !=
    urtfc_parity(rx_data, line_ctl[`URT_LINE_EVEN], line_ctl[`URT_LINE_STICK]));

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_tcnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_sh <= 9'h000;
      rx_done <= 1'b0;
      rx_word <= 11'h000;
    end else begin
      rx_prev <= rxd_in;
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_tcnt <= 4'h0;
          if (rx_prev && !rxd_in) rx_state <= RX_START;
        end
        RX_START: if (tick16) begin
          rx_tcnt <= rx_tcnt + 4'h1;
          if (rx_tcnt == `URT_MID_TICK) begin
            rx_tcnt <= 4'h0;
            rx_idx <= 4'h0;
            rx_sh <= 9'h000;
            rx_state <= rxd_in ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: if (tick16) begin
          rx_tcnt <= rx_tcnt + 4'h1;
          if (rx_tcnt == `URT_LAST_TICK) begin
            rx_sh[rx_idx] <= rxd_in;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == rx_last) rx_state <= RX_STOP;
          end
        end
        RX_STOP: if (tick16) begin
          rx_tcnt <= rx_tcnt + 4'h1;
          if (rx_tcnt == `URT_LAST_TICK) begin
            // flags sit above the data: break, framing, parity
            rx_word <= {!rxd_in && rx_sh == 9'h000, !rxd_in, rx_pe, rx_data};
            rx_done <= 1'b1;
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  urtfc_fifo #(.W(11)) u_rx_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .clr_in(rx_clr),
    .lim_in(lim),
    .push_in(rx_done),
    .push_data_in(rx_word),
    .pop_in(rx_pop),
    .count_out(rx_count),
    .head_out(rx_head)
  );

  // ****************
  // status
  // ****************
  logic overrun;
  logic [4:0] err_cnt;
  logic err_in;
  logic err_out;
  logic [3:0] lvl;
  logic [3:0] delta;
  logic [7:0] lstat;
  logic [4:0] trig_lvl;
  logic pending;

  assign err_in = rx_done && |rx_word[10:8] && rx_count < lim;
  assign err_out = rx_pop && |rx_head[10:8] && rx_count != 5'h00;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overrun <= 1'b0;
    end else if (rx_done && rx_count >= lim) begin
      overrun <= 1'b1; // set wins over the read that clears it
    end else if (lstat_rd) begin
      overrun <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_cnt <= 5'h00;
    end else if (rx_clr) begin
      err_cnt <= 5'h00;
    end else begin
      err_cnt <= err_cnt + 5'(err_in) - 5'(err_out);
    end
  end

  // inputs are clocked already, so one register is the whole history
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lvl <= 4'h0;
      delta <= 4'h0;
    end else begin
      lvl <= {dcd_in, ri_in, dsr_in, cts_in};
      delta <= (mstat_rd ? 4'h0 : delta) | {dcd_in != lvl[3], lvl[2] && !ri_in, dsr_in != lvl[1],
        cts_in != lvl[0]};
    end
  end

  assign lstat = {err_cnt != 5'h00, tx_count == 5'h00 && !tx_busy, tx_count == 5'h00,
    rx_head[10:8] & {3{rx_count != 5'h00}}, overrun, rx_count != 5'h00};

  always_comb begin
    case (trig)
      2'h0: trig_lvl = `URT_TRIG_1;
      2'h1: trig_lvl = `URT_TRIG_4;
      2'h2: trig_lvl = `URT_TRIG_8;
      default: trig_lvl = `URT_TRIG_14;
    endcase
    if (!fifo_en) trig_lvl = `URT_TRIG_1;
  end

  assign pending = (ier[`URT_IER_RDA] && rx_count >= trig_lvl) ||
    (ier[`URT_IER_THRE] && lstat[5]) || (ier[`URT_IER_RLS] && |lstat[4:1]) ||
    (ier[`URT_IER_MS] && |delta);

  // ****************
  // outputs
  // ****************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
      dtr_out <= 1'b0;
      rts_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      irq_out <= pending;
      dtr_out <= modem_ctl[`URT_MODEM_DTR];
      rts_out <= modem_ctl[`URT_MODEM_RTS];
      if (rd_in) begin
        case (addr_in)
          `URT_OFF_DATA: rdata_out <= div_sel ? divisor[7:0] : rx_head[7:0];
          `URT_OFF_IER: rdata_out <= div_sel ? divisor[15:8] : {4'h0, ier};
          `URT_OFF_LINE: rdata_out <= line_ctl;
          `URT_OFF_MODEM: rdata_out <= {6'h00, modem_ctl};
          `URT_OFF_LSTAT: rdata_out <= lstat;
          `URT_OFF_MSTAT: rdata_out <= {lvl, delta};
          `URT_OFF_SCRATCH: rdata_out <= scratch;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_rx_pop_count: assert property (rx_pop && rx_count != 5'h00 && !rx_done && !rx_clr |=>
    rx_count == $past(rx_count) - 5'h01)
    else $error("receive read did not remove one byte");
  chk_tx_push_lands: assert property (tx_push && tx_count == 5'h00 && !tx_clr |=> tx_count == 5'h01
    ##1 tx_busy)
    else $error("written byte did not reach the shifter");
  chk_fifo_clear: assert property (rx_clr |=> rx_count == 5'h00 && err_cnt == 5'h00)
    else $error("receive flush left data behind");
  chk_dtr_follow: assert property (wr_in && addr_in == `URT_OFF_MODEM |=>
    ##1 dtr_out == $past(wdata_in[0], 2) && rts_out == $past(wdata_in[1], 2))
    else $error("modem control did not reach the pins");
  chk_err_summary: assert property (err_cnt != 5'h00 |-> lstat[7] && rx_count >= err_cnt)
    else $error("error summary disagrees with queued bytes");
  chk_ring_trail: assert property (lvl[2] && !ri_in |=> delta[2])
    else $error("ring trailing edge not flagged");
  chk_msr_levels: assert property (##1 lvl == $past({dcd_in, ri_in, dsr_in, cts_in}))
    else $error("modem levels are stale");
  chk_irq_masked: assert property (ier == 4'h0 ##1 ier == 4'h0 |-> !irq_out)
    else $error("interrupt raised with all enables off");
  chk_trig_level: assert property (ier == 4'h1 && fifo_en && trig == 2'h1 && rx_count < `URT_TRIG_4
    && $stable(ier) |=> !irq_out)
    else $error("interrupt below the trigger level");
endmodule : urtfc_core
`default_nettype wire

// ---- rtl/urtfc_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "urtfc_regs.svh"
module urtfc_fifo #(
  parameter int W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic clr_in,
  input wire logic [4:0] lim_in,
  input wire logic push_in,
  input wire logic [W-1:0] push_data_in,
  input wire logic pop_in,
  output logic [4:0] count_out,
  output logic [W-1:0] head_out
);
  import urtfc_pkg::*;
  logic [W-1:0] mem [0:15];
  logic [3:0] wr_ptr;
  logic [3:0] rd_ptr;
  logic push_ok;
  logic pop_ok;
  logic [3:0] next_rd;

  assign push_ok = push_in && (count_out < lim_in);
  assign pop_ok = pop_in && (count_out != 5'h00);
  assign next_rd = clr_in ? wr_ptr : rd_ptr + 4'(pop_ok);

  always_ff @(posedge clk_in) begin
    if (push_ok) begin
      mem[wr_ptr] <= push_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count_out <= 5'h00;
    end else if (clr_in) begin
      rd_ptr <= wr_ptr;
      count_out <= 5'h00;
    end else begin
      wr_ptr <= wr_ptr + 4'(push_ok);
      rd_ptr <= next_rd;
      count_out <= count_out + 5'(push_ok) - 5'(pop_ok);
    end
  end

  // head looks ahead so it is valid in the same cycle as the count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      head_out <= '0;
    end else if (push_ok && wr_ptr == next_rd) begin
      head_out <= push_data_in;
    end else begin
      head_out <= mem[next_rd];
    end
  end
endmodule : urtfc_fifo
`default_nettype wire

// ---- rtl/urtfc_pkg.sv ----
package urtfc_pkg;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} urtfc_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} urtfc_tx_state_t;

  // keeps only the selected word length, 5 to 8 bits
  function automatic logic [7:0] urtfc_mask(input logic [7:0] d, input logic [1:0] wl);
    return d & (8'hFF >> (2'h3 - wl));
  endfunction : urtfc_mask

  function automatic logic urtfc_parity(input logic [7:0] d, input logic even, input logic stick);
    if (stick) begin
      return !even;
    end
    return even ? ^d : ~^d;
  endfunction : urtfc_parity
endpackage : urtfc_pkg

// ---- rtl/urtfc_regs.svh ----
`ifndef URTFC_REGS_SVH
`define URTFC_REGS_SVH
// ****************
// register offsets
// ****************
`define URT_OFF_DATA 3'h0
`define URT_OFF_IER 3'h1
`define URT_OFF_FIFO 3'h2
`define URT_OFF_LINE 3'h3
`define URT_OFF_MODEM 3'h4
`define URT_OFF_LSTAT 3'h5
`define URT_OFF_MSTAT 3'h6
`define URT_OFF_SCRATCH 3'h7
// ****************
// field positions
// ****************
`define URT_LINE_DIVSEL 7
`define URT_LINE_BREAK 6
`define URT_LINE_STICK 5
`define URT_LINE_EVEN 4
`define URT_LINE_PAR 3
`define URT_LINE_STOP 2
`define URT_FIFO_EN 0
`define URT_FIFO_RXCLR 1
`define URT_FIFO_TXCLR 2
`define URT_IER_RDA 0
`define URT_IER_THRE 1
`define URT_IER_RLS 2
`define URT_IER_MS 3
`define URT_MODEM_DTR 0
`define URT_MODEM_RTS 1
// ****************
// reset values and counts
// ****************
`define URT_DIV_RST 16'h0000
`define URT_CLK_HZ 125000000
`define URT_BASE_BAUD 115200
`define URT_OVERSAMPLE 16
`define URT_REF_HZ (`URT_BASE_BAUD * `URT_OVERSAMPLE)
`define URT_FIFO_DEPTH 5'h10
`define URT_MID_TICK 4'h7
`define URT_LAST_TICK 4'hF
`define URT_TRIG_1 5'h01
`define URT_TRIG_4 5'h04
`define URT_TRIG_8 5'h08
`define URT_TRIG_14 5'h0E
`endif

// ---- rtl/urtfc_tx.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "urtfc_regs.svh"
module urtfc_tx (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tick_in,
  input wire logic valid_in,
  input wire logic [7:0] data_in,
  input wire logic [5:0] fmt_in,
  output logic take_out,
  output logic busy_out,
  output logic line_out
);
  import urtfc_pkg::*;
  urtfc_tx_state_t state;
  logic [11:0] sh;
  logic [3:0] left;
  logic [3:0] tcnt;
  logic [3:0] len;
  logic [2:0] tail;
  logic [11:0] body;
  logic [11:0] frame;
  logic [3:0] nbits;
  logic [7:0] md;

  assign len = 4'h5 + 4'(fmt_in[1:0]);
  assign md = urtfc_mask(data_in, fmt_in[1:0]);
  assign tail = fmt_in[`URT_LINE_PAR] ?
    {2'b11, urtfc_parity(md, fmt_in[`URT_LINE_EVEN], fmt_in[`URT_LINE_STICK])} : 3'b111;
  assign body = (12'(tail) << len) | 12'(md);
  assign frame = {body[10:0], 1'b0}; // start low, data lsb first, parity, stops high
  assign nbits = 4'h1 + len + 4'(fmt_in[`URT_LINE_PAR]) + (fmt_in[`URT_LINE_STOP] ? 4'h2 : 4'h1);
  assign take_out = valid_in && state == TX_IDLE;
  assign busy_out = state != TX_IDLE;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= TX_IDLE;
      sh <= 12'hFFF;
      left <= 4'h0;
      tcnt <= 4'h0;
      line_out <= 1'b1;
    end else begin
      case (state)
        TX_IDLE: begin
          line_out <= 1'b1;
          if (valid_in) begin
            sh <= frame;
            left <= nbits - 4'h1;
            tcnt <= 4'h0;
            line_out <= frame[0];
            state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tick_in) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == `URT_LAST_TICK) begin
              if (left == 4'h0) begin
                line_out <= 1'b1;
                state <= TX_IDLE;
              end else begin
                sh <= {1'b1, sh[11:1]};
                line_out <= sh[1];
                left <= left - 4'h1;
              end
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_start_bit_low: assert property (take_out |=> !line_out)
    else $error("frame did not open with a low start bit");
  chk_stop_bit_high: assert property ($fell(busy_out) |-> line_out && $past(line_out))
    else $error("frame did not end on a high stop bit");
endmodule : urtfc_tx
`default_nettype wire

// ---- tb/urtfc_core_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module urtfc_core_bench;
  // ****************
  // clock, reset and wiring
  // ****************
  logic clk_in, rst_in, wr_in, rd_in, cts_in, dsr_in, ri_in, dcd_in;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, v, d;
  logic [7:0] w[4];
  logic [3:0] p, m;
  logic rxd_w, txd_w, dtr_w, rts_w, irq_w;
  logic [7:0] rdata_w;
  int err_total, samples_checked, cyc;

  urtfc_core dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_w), .rxd_in(rxd_w), .txd_out(txd_w), .cts_in(cts_in),
    .dsr_in(dsr_in), .ri_in(ri_in), .dcd_in(dcd_in), .dtr_out(dtr_w), .rts_out(rts_w), .irq_out(irq_w));
  urtfc_term term (.clk_in(clk_in), .line_in(txd_w), .line_out(rxd_w));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // ****************
  // bus tasks and expectations
  // ****************
  task automatic wr(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= x;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  // read data is registered at the taking edge, so it is picked up one edge later
  task automatic rd(input logic [2:0] a, output logic [7:0] x);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    #1 x = rdata_w;
  endtask : rd

  // ring flags only its trailing edge, the others any change
  function automatic logic [7:0] msr_exp(input logic [3:0] pv, input logic [3:0] mv);
    return {mv, pv[3] ^ mv[3], pv[2] & ~mv[2], pv[1:0] ^ mv[1:0]};
  endfunction : msr_exp

  function automatic int trig_lvl(input logic [1:0] s);
    case (s)
      2'b00: return 1;
      2'b01: return 4;
      2'b10: return 8;
      default: return 14;
    endcase
  endfunction : trig_lvl

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      $display("[FAIL] run time exp %h got %h", 80000, cyc);
      complete_run();
    end
  end

  // ****************
  // tests
  // ****************
  initial begin
    v = $urandom(75664);
    rst_in = 1'b1;
    {wr_in, rd_in, cts_in, dsr_in, ri_in, dcd_in} = 6'h00;
    addr_in = 3'h0;
    wdata_in = 8'h00;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1 `CHK("txd idle", 1'b1, txd_w)
    rd(3'h3, d);
    `CHK("line_control rst", 8'h00, d)
    rd(3'h5, d);
    `CHK("line_status rst", 8'h60, d)
    rd(3'h2, d);
    `CHK("offset 2 read", 8'h00, d)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(3'h7, v);
      rd(3'h7, d);
      `CHK("scratch_byte", v, d)
      wr(3'h4, v);
      @(posedge clk_in);
      #1 `CHK("dtr", v[0], dtr_w)
      `CHK("rts", v[1], rts_w)
      wr(3'h3, {2'b10, v[5:0]});
      wr(3'h0, v ^ 8'h3C);
      wr(3'h1, ~v);
      rd(3'h0, d);
      `CHK("divisor_low", v ^ 8'h3C, d)
      rd(3'h1, d);
      `CHK("divisor_high", ~v, d)
      rd(3'h3, d);
      `CHK("line_control", {2'b10, v[5:0]}, d)
      wr(3'h3, {2'b00, v[5:0]});
      wr(3'h1, v);
      rd(3'h1, d);
      `CHK("interrupt_enables", {4'h0, v[3:0]}, d)
    end
    wr(3'h1, 8'h00);
    $display("test registers done");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h03);
    v = $urandom;
    wr(3'h0, v);
    rd(3'h5, d);
    `CHK("shifter empty", 1'b0, d[6])
    for (int n = 0; n < 20000 && term.got.size() == 0; n++) @(posedge clk_in);
    d = (term.got.size() != 0) ? term.got.pop_front() : ~v;
    `CHK("sent byte", v, d)
    wr(3'h3, 8'h43);
    @(posedge clk_in);
    #1 `CHK("break", 1'b0, txd_w)
    $display("test transmit done");
    wr(3'h3, 8'h1B);
    v = $urandom;
    term.send(v, 1'b1, 1'b1);
    rd(3'h5, d);
    `CHK("line_status err", 8'h85, d & 8'h8D)
    rd(3'h0, d);
    `CHK("receive_buffer", v, d)
    rd(3'h5, d);
    `CHK("line_status clr", 8'h00, d & 8'h8D)
    $display("test parity error done");
    wr(3'h1, 8'h08);
    p = 4'h0;
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 4'h0 : 4'($urandom);
      @(posedge clk_in);
      {dcd_in, ri_in, dsr_in, cts_in} <= m;
      repeat (3) @(posedge clk_in);
      #1 `CHK("irq modem", |(msr_exp(p, m) & 8'h0F), irq_w)
      rd(3'h6, d);
      `CHK("modem_status", msr_exp(p, m), d)
      `CHK("irq after read", 1'b0, irq_w)
      p = m;
    end
    $display("test modem status done");
    wr(3'h3, 8'h03);
    wr(3'h2, 8'h41);
    wr(3'h1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      w[i] = $urandom;
      term.send(w[i], 1'b0, 1'b0);
      repeat (3) @(posedge clk_in);
      #1 `CHK("irq trigger", (i + 1 >= trig_lvl(2'b01)), irq_w)
    end
    for (int i = 0; i < 2; i++) begin
      rd(3'h0, d);
      `CHK("fifo order", w[i], d)
    end
    wr(3'h2, 8'h43);
    rd(3'h5, d);
    `CHK("rx cleared", 1'b0, d[0])
    $display("test receive fifo done");
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h03);
    for (int i = 0; i < 3; i++) wr(3'h0, 8'($urandom));
    rd(3'h5, d);
    `CHK("tx queued", 1'b0, d[5])
    wr(3'h2, 8'h05);
    rd(3'h5, d);
    `CHK("tx cleared", 1'b1, d[5])
    $display("test transmit clear done");
    complete_run();
  end
endmodule : urtfc_core_bench
`default_nettype wire

// ---- tb/urtfc_term.sv ----
`timescale 1ns/10ps
`default_nettype none
module urtfc_term #(
  parameter int BIT_CYC = 1085
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic line_out
);
  // ****************
  // remote terminal, 8 data bits, one stop
  // ****************
  // bit timing counts clock cycles so no edge of the line lands on a sampling edge
  logic [7:0] got[$];
  logic [7:0] sh;
  initial line_out = 1'b1;

  task automatic bit_out(input logic b);
    line_out = b;
    repeat (BIT_CYC) @(negedge clk_in);
  endtask : bit_out

  task automatic send(input logic [7:0] d, input logic par_en, input logic par_bad);
    @(negedge clk_in);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    if (par_en) begin
      bit_out(^d ^ par_bad);
    end
    bit_out(1'b1);
  endtask : send

  // samples mid bit; drift of the far clock is far below half a bit over one frame
  always begin
    @(negedge line_in);
    repeat (BIT_CYC + BIT_CYC / 2) @(negedge clk_in);
    for (int i = 0; i < 8; i++) begin
      sh[i] = line_in;
      repeat (BIT_CYC) @(negedge clk_in);
    end
    got.push_back(sh);
  end
endmodule : urtfc_term
`default_nettype wire
